// ==== nvmcb_pkg.sv ====
// Behaviour
// - Two nonvolatile bits, set/clear commands only
// - Bit 0 set enables brownout detector
// - Erase pin clears bit 0
// - Bit 1 drives brownout reset enable
// - Erase pin clears brownout reset enable
// - Eight factory calibration bits, never modified
// - Fast mode only with all straps high
// - Fast interface over JTAG or parallel handshake
// - Fast interface accepts seven programmer commands
package nvmcb_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_CAL = 8'h08;
    localparam logic [7:0] ADDR_FPCMD = 8'h0c;
    localparam int CMD_SET_POS = 0;
    localparam int CMD_CLR_POS = 1;
    localparam int CMD_BIT_POS = 8;
    localparam int NVM_BITS = 2;
    localparam int CAL_BITS = 8;
    localparam logic [1:0] NVM_RESET = 2'h0;
    localparam logic [7:0] CAL_DEFAULT = 8'h80;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0]
    {
        FP_READ = 3'h0,
        FP_PAGE_PROG = 3'h1,
        FP_PAGE_ERASE = 3'h2,
        FP_FULL_ERASE = 3'h3,
        FP_LOCK = 3'h4,
        FP_UNLOCK = 3'h5,
        FP_PROTECT = 3'h6
    } nvmcb_fpcmd_type;

    typedef struct packed
    {
        logic testStrapPin;
        logic portStrapPinLow;
        logic portStrapPinHigh;
    } nvmcb_strap_type;
endpackage : nvmcb_pkg

// ==== nvmcb_fast_prog.sv ====
`timescale 1ns/100ps
module nvmcb_fast_prog
(
    input wire logic core_clk,
    input wire logic reset,
    input wire nvmcb_pkg::nvmcb_strap_type straps,
    input wire logic jtagSelect,
    input wire logic parStrobe,
    input wire logic [2:0] parCmd,
    input wire logic jtagValid,
    input wire logic [2:0] jtagCmd,
    output logic fastMode,
    output logic parAck,
    output logic cmdValid,
    output nvmcb_pkg::nvmcb_fpcmd_type cmdCode,
    output logic cmdBad
);
    import nvmcb_pkg::*;
    typedef struct packed
    {
        logic mode;
        logic ack;
        logic valid;
        nvmcb_fpcmd_type code;
        logic bad;
    } nvmcb_fp_type;
    nvmcb_fp_type st_q, st_d;
    logic [2:0] raw;
    logic take;

    always_comb
    begin
        st_d = st_q;
        st_d.valid = 1'b0;
        st_d.bad = 1'b0;
        // All three straps must be high for fast mode
        st_d.mode = straps.testStrapPin & straps.portStrapPinLow
            & straps.portStrapPinHigh;
        raw = jtagSelect ? jtagCmd : parCmd;
        take = 1'b0;
        if (st_q.mode && jtagSelect && jtagValid)
        begin
            take = 1'b1;
        end
        // Parallel port: strobe raises ack, strobe low drops it
        if (st_q.mode && !jtagSelect && parStrobe && !st_q.ack)
        begin
            take = 1'b1;
            st_d.ack = 1'b1;
        end
        if (!parStrobe || !st_q.mode)
        begin
            st_d.ack = 1'b0;
        end
        if (take)
        begin
            if (raw <= 3'h6)
            begin
                st_d.valid = 1'b1;
                st_d.code = nvmcb_fpcmd_type'(raw);
            end
            else
            begin
                st_d.bad = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            st_q <= '{1'b0, 1'b0, 1'b0, FP_READ, 1'b0};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign fastMode = st_q.mode;
    assign parAck = st_q.ack;
    assign cmdValid = st_q.valid;
    assign cmdCode = st_q.code;
    assign cmdBad = st_q.bad;
endmodule : nvmcb_fast_prog

// ==== nvmcb_top.sv ====
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
module nvmcb_top
#(
    parameter logic [7:0] CAL_VALUE = nvmcb_pkg::CAL_DEFAULT
)
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic erasePin,
    input wire logic brownoutDetected,
    input wire nvmcb_pkg::nvmcb_strap_type straps,
    input wire logic jtagSelect,
    input wire logic parStrobe,
    input wire logic [2:0] parCmd,
    input wire logic jtagValid,
    input wire logic [2:0] jtagCmd,
    output logic brownoutDetectorEnable,
    output logic brownoutResetEnable,
    output logic brownoutResetRequest,
    output logic [7:0] calibrationBits,
    output logic fastMode,
    output logic parAck,
    output logic fpCmdValid,
    output nvmcb_pkg::nvmcb_fpcmd_type fpCmdCode
);
    import nvmcb_pkg::*;

    typedef struct packed
    {
        logic [1:0] nvm;
        logic awHeld;
        logic [7:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic bdEn;
        logic brEn;
        logic rstReq;
        logic [2:0] lastCmd;
        logic badSeen;
        logic awRdy;
        logic wRdy;
        logic arRdy;
        logic [7:0] cal;
    } nvmcb_state_type;

    // Power-up value of the cells; reset leaves them alone
    nvmcb_state_type st_q = '{nvm: NVM_RESET, default: '0};
    nvmcb_state_type st_d;
    logic fpMode, fpAck, fpValid, fpBad;
    nvmcb_fpcmd_type fpCode;

    nvmcb_fast_prog u_fast_prog
    (
        .core_clk(core_clk),
        .reset(reset),
        .straps(straps),
        .jtagSelect(jtagSelect),
        .parStrobe(parStrobe),
        .parCmd(parCmd),
        .jtagValid(jtagValid),
        .jtagCmd(jtagCmd),
        .fastMode(fpMode),
        .parAck(fpAck),
        .cmdValid(fpValid),
        .cmdCode(fpCode),
        .cmdBad(fpBad)
    );

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == ADDR_CTRL) || (a == ADDR_STAT)
            || (a == ADDR_CAL) || (a == ADDR_FPCMD);
    endfunction : mapped

    always_comb
    begin
        st_d = st_q;
        if (s_axi_awvalid && !st_q.awHeld)
        begin
            st_d.awHeld = 1'b1;
            st_d.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_q.wHeld)
        begin
            st_d.wHeld = 1'b1;
            st_d.wData = s_axi_wdata;
            st_d.wStrb = s_axi_wstrb;
        end
        if (st_q.bValid && s_axi_bready)
        begin
            st_d.bValid = 1'b0;
        end
        // Write completes once both halves held and no response pending
        if (st_q.awHeld && st_q.wHeld && !st_q.bValid)
        begin
            st_d.awHeld = 1'b0;
            st_d.wHeld = 1'b0;
            st_d.bValid = 1'b1;
            st_d.bResp = RESP_OKAY;
            if (st_q.awAddr == ADDR_CTRL)
            begin
                // Only set/clear commands touch the bits; no direct write
                if (st_q.wStrb[0] && st_q.wData[CMD_SET_POS])
                begin
                    st_d.nvm[st_q.wData[CMD_BIT_POS]] = 1'b1;
                end
                else if (st_q.wStrb[0] && st_q.wData[CMD_CLR_POS])
                begin
                    st_d.nvm[st_q.wData[CMD_BIT_POS]] = 1'b0;
                end
            end
            else if (!mapped(st_q.awAddr) || st_q.awAddr == ADDR_CAL)
            begin
                // Calibration is read-only; writes refused
                st_d.bResp = RESP_SLVERR;
            end
        end
        if (st_q.rValid && s_axi_rready)
        begin
            st_d.rValid = 1'b0;
        end
        if (s_axi_arvalid && !st_q.rValid)
        begin
            st_d.rValid = 1'b1;
            st_d.rResp = RESP_OKAY;
            st_d.rData = 32'h0;
            unique case (s_axi_araddr)
                ADDR_CTRL: st_d.rData = {30'h0, st_q.nvm};
                ADDR_STAT: st_d.rData = {26'h0, st_q.badSeen, fpMode,
                    st_q.rstReq, st_q.brEn, st_q.bdEn, brownoutDetected};
                ADDR_CAL: st_d.rData = {24'h0, CAL_VALUE};
                ADDR_FPCMD: st_d.rData = {29'h0, st_q.lastCmd};
                default: st_d.rResp = RESP_SLVERR;
            endcase
        end
        if (fpValid)
        begin
            st_d.lastCmd = fpCode;
        end
        if (fpBad)
        begin
            st_d.badSeen = 1'b1;
        end
        // Erase wins over any command in the same cycle
        if (erasePin)
        begin
            st_d.nvm[0] = 1'b0;
            st_d.nvm[1] = 1'b0;
        end
        st_d.bdEn = st_d.nvm[0];
        st_d.brEn = st_d.nvm[1];
        st_d.rstReq = st_q.bdEn & brownoutDetected & st_q.brEn;
        // Readies registered so every bus output leaves a flop
        st_d.awRdy = !st_d.awHeld;
        st_d.wRdy = !st_d.wHeld;
        st_d.arRdy = !st_d.rValid;
        st_d.cal = CAL_VALUE;
    end

    // Reset clears bus flags, responses, rstReq, badSeen and lastCmd but not held address/data; the bits model nonvolatile cells
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            st_q.awHeld <= 1'b0;
            st_q.wHeld <= 1'b0;
            st_q.bValid <= 1'b0;
            st_q.rValid <= 1'b0;
            st_q.rstReq <= 1'b0;
            st_q.badSeen <= 1'b0;
            st_q.awAddr <= st_d.awAddr;
            st_q.wData <= st_d.wData;
            st_q.wStrb <= st_d.wStrb;
            st_q.bResp <= RESP_OKAY;
            st_q.rData <= 32'h0;
            st_q.rResp <= RESP_OKAY;
            st_q.lastCmd <= 3'h0;
            st_q.nvm <= st_q.nvm;
            st_q.bdEn <= st_q.nvm[0];
            st_q.brEn <= st_q.nvm[1];
            st_q.awRdy <= 1'b1;
            st_q.wRdy <= 1'b1;
            st_q.arRdy <= 1'b1;
            st_q.cal <= CAL_VALUE;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign s_axi_awready = st_q.awRdy;
    assign s_axi_wready = st_q.wRdy;
    assign s_axi_bvalid = st_q.bValid;
    assign s_axi_bresp = st_q.bResp;
    assign s_axi_arready = st_q.arRdy;
    assign s_axi_rvalid = st_q.rValid;
    assign s_axi_rdata = st_q.rData;
    assign s_axi_rresp = st_q.rResp;
    assign brownoutDetectorEnable = st_q.bdEn;
    assign brownoutResetEnable = st_q.brEn;
    assign brownoutResetRequest = st_q.rstReq;
    assign calibrationBits = st_q.cal;
    assign fastMode = fpMode;
    assign parAck = fpAck;
    assign fpCmdValid = fpValid;
    assign fpCmdCode = fpCode;
endmodule : nvmcb_top

// ==== nvmcb_checker.sv ====
`timescale 1ns/100ps
module nvmcb_checker
#(
    parameter logic [7:0] CAL_VALUE = nvmcb_pkg::CAL_DEFAULT
)
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic erasePin,
    input wire logic brownoutDetected,
    input wire nvmcb_pkg::nvmcb_strap_type straps,
    input wire logic parStrobe,
    input wire logic parAck,
    input wire logic brownoutDetectorEnable,
    input wire logic brownoutResetEnable,
    input wire logic brownoutResetRequest,
    input wire logic [7:0] calibrationBits,
    input wire logic fastMode
);
    import nvmcb_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    property p_erase_det; erasePin [*2] |=> !brownoutDetectorEnable; endproperty
    a_erase_det: assert property (p_erase_det)
        else $error("detector enable kept through erase");
    property p_erase_rst; erasePin [*2] |=> !brownoutResetEnable; endproperty
    a_erase_rst: assert property (p_erase_rst)
        else $error("reset enable kept through erase");
    property p_cal; calibrationBits == CAL_VALUE; endproperty
    a_cal: assert property (p_cal)
        else $error("calibration bits changed");
    property p_req_src; brownoutResetRequest |-> $past(brownoutDetected);
    endproperty
    a_req_src: assert property (p_req_src)
        else $error("reset request without brownout");
    property p_req_on;
        (brownoutDetected && brownoutDetectorEnable && brownoutResetEnable)
            [*2] |=> brownoutResetRequest;
    endproperty
    a_req_on: assert property (p_req_on)
        else $error("reset request missing");
    property p_fast_on; straps == 3'h7 [*2] |=> fastMode; endproperty
    a_fast_on: assert property (p_fast_on)
        else $error("fast mode not entered");
    property p_fast_off; straps != 3'h7 |=> !fastMode; endproperty
    a_fast_off: assert property (p_fast_off)
        else $error("fast mode without all straps");
    property p_ack; $rose(parAck) |-> $past(parStrobe); endproperty
    a_ack: assert property (p_ack)
        else $error("acknowledge without strobe");
    c_req: cover property (brownoutResetRequest);
    c_ack: cover property ($rose(parAck));
    c_erase: cover property (erasePin && brownoutResetEnable);
endmodule : nvmcb_checker

bind nvmcb_top nvmcb_checker #(.CAL_VALUE(CAL_VALUE)) u_chk (.*);

// ==== nvmcb_prog_model.sv ====
`timescale 1ns/100ps
module nvmcb_prog_model
(
    input wire logic core_clk,
    input wire logic parAck,
    output nvmcb_pkg::nvmcb_strap_type straps,
    output logic jtagSelect,
    output logic parStrobe,
    output logic [2:0] parCmd,
    output logic jtagValid,
    output logic [2:0] jtagCmd
);
    import nvmcb_pkg::*;
    initial
    begin
        straps = '0;
        {jtagSelect, parStrobe, jtagValid, parCmd, jtagCmd} = '0;
    end
    task strap(input logic [2:0] s);
        straps <= s;
    endtask : strap
    // Released command lines show the inverse, so a stale code never matches the one just sent
    task send(input logic j, input logic [2:0] c, output logic ok);
        int n;
        jtagSelect <= j;
        @(posedge core_clk);
        if (j)
        begin
            jtagCmd <= c;
            jtagValid <= 1'h1;
            @(posedge core_clk);
            jtagValid <= 1'h0;
            jtagCmd <= ~c;
            ok = 1'h1;
        end
        else
        begin
            parCmd <= c;
            parStrobe <= 1'h1;
            for (n = 0; n < 9 && parAck !== 1'h1; n++) @(posedge core_clk);
            ok = (parAck === 1'h1);
            parStrobe <= 1'h0;
            parCmd <= ~c;
            for (n = 0; n < 9 && parAck !== 1'h0; n++) @(posedge core_clk);
            ok = ok && (parAck === 1'h0);
        end
    endtask : send
endmodule : nvmcb_prog_model

// ==== nvmcb_top_tb.sv ====
`timescale 1ns/100ps
module nvmcb_top_tb;
    import nvmcb_pkg::*;
    localparam logic [7:0] CAL = 8'h5a; // Arbitrary
    logic core_clk = 1'h0, reset = 1'h1, erasePin = 1'h0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, calibrationBits;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, brownoutDetected = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, ok;
    logic s_axi_rvalid, parAck, fastMode, fpCmdValid, jtagSelect, jtagValid;
    logic brownoutDetectorEnable, brownoutResetEnable, brownoutResetRequest;
    logic parStrobe;
    logic [2:0] parCmd, jtagCmd;
    nvmcb_strap_type straps;
    nvmcb_fpcmd_type fpCmdCode;
    int miscompares = 0, total_checks = 0;
    int pulses = 0;
    nvmcb_top #(.CAL_VALUE(CAL)) u_dut (.*);
    nvmcb_prog_model u_prog (.*);
    initial forever #12.5 core_clk = ~core_clk;
    // Counts one-cycle command strobes from the fast interface
    always @(posedge core_clk)
        if (fpCmdValid === 1'h1) pulses <= pulses + 1;
    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test
    task hang;
        miscompares++;
        end_of_test();
    endtask : hang
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e)
        begin
            miscompares++;
            $display("mismatch %s exp %h got %h", nm, e, s);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (n = 0; n < 40 && s_axi_bvalid !== 1'h1; n++)
        begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end
        s_axi_bready <= 1'h0;
        r = s_axi_bresp;
        if (n == 40) hang();
    endtask : wr
    task rd(input logic [7:0] a);
        int n;
        @(posedge core_clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (n = 0; n < 40 && s_axi_rvalid !== 1'h1; n++)
        begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end
        s_axi_rready <= 1'h0;
        d = s_axi_rdata;
        r = s_axi_rresp;
        if (n == 40) hang();
    endtask : rd
    task rc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk("rdata", e, d);
        chk("rresp", RESP_OKAY, r);
    endtask : rc
    task t_bits;
        wr(ADDR_CTRL, 32'h1);
        rc(ADDR_CTRL, 32'h1);
        chk("detEn", 1'h1, brownoutDetectorEnable);
        wr(ADDR_CTRL, 32'h101);
        rc(ADDR_CTRL, 32'h3);
        chk("rstEn", 1'h1, brownoutResetEnable);
        wr(ADDR_CTRL, 32'h2);
        rc(ADDR_CTRL, 32'h2);
        chk("detEn", 1'h0, brownoutDetectorEnable);
        // Mid-run reset: the cells must survive it
        reset <= 1'h1;
        repeat (2) @(posedge core_clk);
        reset <= 1'h0;
        rc(ADDR_CTRL, 32'h2);
        chk("rstEn", 1'h1, brownoutResetEnable);
        $display("bits test done");
    endtask : t_bits
    task t_bod;
        brownoutDetected <= 1'h1;
        repeat (3) @(posedge core_clk);
        chk("req", 1'h0, brownoutResetRequest);
        wr(ADDR_CTRL, 32'h1);
        repeat (2) @(posedge core_clk);
        chk("req", 1'h1, brownoutResetRequest);
        wr(ADDR_CTRL, 32'h102);
        repeat (2) @(posedge core_clk);
        chk("req", 1'h0, brownoutResetRequest);
        brownoutDetected <= 1'h0;
        $display("brownout test done");
    endtask : t_bod
    task t_erase;
        wr(ADDR_CTRL, 32'h101);
        erasePin <= 1'h1;
        repeat (3) @(posedge core_clk);
        erasePin <= 1'h0;
        rc(ADDR_CTRL, 32'h0);
        chk("cal", CAL, calibrationBits);
        wr(ADDR_CAL, 32'h0);
        chk("bresp", RESP_SLVERR, r);
        rc(ADDR_CAL, CAL);
        rd(8'h10);
        chk("rresp", RESP_SLVERR, r);
        chk("rdata", 32'h0, d);
        $display("erase test done");
    endtask : t_erase
    task t_fast;
        for (int s = 0; s < 8; s++)
        begin
            u_prog.strap(s[2:0]);
            repeat (2) @(posedge core_clk);
            chk("fast", s == 7, fastMode);
        end
        for (int c = 0; c < 7; c++)
        begin
            u_prog.send(c[0], c[2:0], ok);
            if (!ok) hang();
            rc(ADDR_FPCMD, c);
            chk("code", c, fpCmdCode);
        end
        u_prog.send(1'h1, 3'h7, ok);
        rc(ADDR_STAT, 32'h30);
        // Straps not all high: commands must be ignored
        u_prog.strap(3'h6);
        repeat (2) @(posedge core_clk);
        u_prog.send(1'h1, 3'h2, ok);
        repeat (2) @(posedge core_clk);
        chk("pulses", 32'h7, pulses);
        rc(ADDR_FPCMD, 32'h6);
        $display("fast test done");
    endtask : t_fast
    initial
    begin
        repeat (2) @(posedge core_clk);
        reset <= 1'h0;
        t_bits();
        t_bod();
        t_erase();
        t_fast();
        end_of_test();
    end
endmodule : nvmcb_top_tb
